// ===== shared/bbiow_pkg.sv
package bbiow_pkg;
  localparam logic [7:0] BBIOW_OFS_UPPER_BASE = 8'h14;
  localparam logic [7:0] BBIOW_OFS_BUS_NUM = 8'h18;
  localparam logic [7:0] BBIOW_OFS_IO_WIN = 8'h1C;
  localparam logic [1:0] BBIOW_TYPE_32 = 2'h0;
  localparam logic [1:0] BBIOW_TYPE_64 = 2'h2;
  localparam logic [31:0] BBIOW_UPPER_BASE_RST = 32'h00000000;
  localparam logic [7:0] BBIOW_BUS_RST = 8'h00;
  localparam logic [3:0] BBIOW_IO_NIB_RST = 4'h0;
  localparam logic [3:0] BBIOW_IO_32_IND = 4'h1;
  localparam logic [11:0] BBIOW_IO_LOW_BOTTOM = 12'h000;
  localparam logic [11:0] BBIOW_IO_LOW_TOP = 12'hFFF;
  localparam int BBIOW_PRI_LSB = 0;
  localparam int BBIOW_SEC_LSB = 8;
  localparam int BBIOW_SUB_LSB = 16;
  localparam int BBIOW_IOB_LSB = 4;
  localparam int BBIOW_IOL_LSB = 12;
endpackage : bbiow_pkg

// ===== hw/bbiow_regs.sv
`timescale 1ns/1ps
module bbiow_regs (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CFG_WR_IN,
  input wire logic CFG_RD_IN,
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic [31:0] CFG_WDATA_IN,
  input wire logic [3:0] CFG_BE_IN,
  input wire logic [1:0] BAR_TYPE_IN,
  input wire logic PRELOAD_IN,
  input wire logic [7:0] PRELOAD_ADDR_IN,
  input wire logic [31:0] PRELOAD_DATA_IN,
  input wire logic [15:0] IO_UPPER_BASE_IN,
  input wire logic [15:0] IO_UPPER_LIMIT_IN,
  input wire logic IO_REQ_IN,
  input wire logic [31:0] IO_ADDR_IN,
  output logic [31:0] CFG_RDATA_OUT,
  output logic CFG_RVALID_OUT,
  output logic [31:0] UPPER_BASE_OUT,
  output logic [7:0] PRI_BUS_OUT,
  output logic [7:0] SEC_BUS_OUT,
  output logic [7:0] SUB_BUS_OUT,
  output logic [31:0] IO_BOTTOM_OUT,
  output logic [31:0] IO_TOP_OUT,
  output logic IO_FWD_OUT
);
  import bbiow_pkg::*;

  // ************************************************
  // write port selection
  // ************************************************
  logic [31:0] wd;
  logic [3:0] be;
  logic [7:0] wa;
  logic we;
  logic type_64;
  logic sel_upper;
  logic sel_bus;
  logic sel_io;

  always_comb begin
    // preload has priority over a config write in the same cycle
    we = PRELOAD_IN | CFG_WR_IN;
    wa = PRELOAD_IN ? PRELOAD_ADDR_IN : CFG_ADDR_IN;
    wd = PRELOAD_IN ? PRELOAD_DATA_IN : CFG_WDATA_IN;
    be = PRELOAD_IN ? 4'hF : CFG_BE_IN;
    type_64 = BAR_TYPE_IN == BBIOW_TYPE_64;
    sel_upper = we && wa == BBIOW_OFS_UPPER_BASE && type_64;
    sel_bus = we && wa == BBIOW_OFS_BUS_NUM;
    sel_io = we && wa == BBIOW_OFS_IO_WIN;
  end

  // ************************************************
  // upper base address register
  // ************************************************
  logic [31:0] upper_base_r;
  logic [31:0] upper_base_nxt;

  always_comb begin
    upper_base_nxt = upper_base_r;
    for (int i = 0; i < 4; i++) begin
      if (sel_upper && be[i]) begin
        upper_base_nxt[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      upper_base_r <= BBIOW_UPPER_BASE_RST;
    end else begin
      upper_base_r <= upper_base_nxt;
    end
  end

  // ************************************************
  // bus number registers
  // ************************************************
  logic [7:0] pri_r;
  logic [7:0] pri_nxt;
  logic [7:0] sec_r;
  logic [7:0] sec_nxt;
  logic [7:0] sub_r;
  logic [7:0] sub_nxt;

  always_comb begin
    // numbers come from software; the block only stores them
    pri_nxt = pri_r;
    sec_nxt = sec_r;
    sub_nxt = sub_r;
    if (sel_bus && be[0]) begin
      pri_nxt = wd[BBIOW_PRI_LSB +: 8];
    end
    if (sel_bus && be[1]) begin
      sec_nxt = wd[BBIOW_SEC_LSB +: 8];
    end
    if (sel_bus && be[2]) begin
      sub_nxt = wd[BBIOW_SUB_LSB +: 8];
    end
    // byte 3 is the reserved latency timer, writes dropped
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      pri_r <= BBIOW_BUS_RST;
      sec_r <= BBIOW_BUS_RST;
      sub_r <= BBIOW_BUS_RST;
    end else begin
      pri_r <= pri_nxt;
      sec_r <= sec_nxt;
      sub_r <= sub_nxt;
    end
  end

  // ************************************************
  // io base and limit nibbles
  // ************************************************
  logic [3:0] iob_r;
  logic [3:0] iob_nxt;
  logic [3:0] iol_r;
  logic [3:0] iol_nxt;

  always_comb begin
    iob_nxt = iob_r;
    iol_nxt = iol_r;
    if (sel_io && be[0]) begin
      iob_nxt = wd[BBIOW_IOB_LSB +: 4];
    end
    if (sel_io && be[1]) begin
      iol_nxt = wd[BBIOW_IOL_LSB +: 4];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      iob_r <= BBIOW_IO_NIB_RST;
      iol_r <= BBIOW_IO_NIB_RST;
    end else begin
      iob_r <= iob_nxt;
      iol_r <= iol_nxt;
    end
  end

  // ************************************************
  // read path
  // ************************************************
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    rvalid_nxt = CFG_RD_IN;
    // data bus idles at zero between reads
    rdata_nxt = 32'h00000000;
    if (CFG_RD_IN) begin
      case (CFG_ADDR_IN)
        BBIOW_OFS_UPPER_BASE: begin
          rdata_nxt = upper_base_r;
        end
        BBIOW_OFS_BUS_NUM: begin
          rdata_nxt = {8'h00, sub_r, sec_r, pri_r};
        end
        BBIOW_OFS_IO_WIN: begin
          rdata_nxt = {16'h0000, iol_r, BBIOW_IO_32_IND, iob_r, BBIOW_IO_32_IND};
        end
        default: begin
          rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ************************************************
  // io window and forwarding decision
  // ************************************************
  logic [31:0] bot_r;
  logic [31:0] bot_nxt;
  logic [31:0] top_r;
  logic [31:0] top_nxt;
  logic fwd_r;
  logic fwd_nxt;
  logic hit_lo;
  logic hit_hi;

  always_comb begin
    // upper halves come from the separate upper registers outside
    bot_nxt = {IO_UPPER_BASE_IN, iob_r, BBIOW_IO_LOW_BOTTOM};
    top_nxt = {IO_UPPER_LIMIT_IN, iol_r, BBIOW_IO_LOW_TOP};
    // both ends inclusive; bottom above top gives an empty window
    hit_lo = IO_ADDR_IN >= bot_r;
    hit_hi = IO_ADDR_IN <= top_r;
    fwd_nxt = IO_REQ_IN && hit_lo && hit_hi;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      bot_r <= 32'h00000000;
      top_r <= 32'h00000000;
      fwd_r <= 1'b0;
    end else begin
      bot_r <= bot_nxt;
      top_r <= top_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  // ************************************************
  // outputs, all straight from flip-flops
  // ************************************************
  assign CFG_RDATA_OUT = rdata_r;
  assign CFG_RVALID_OUT = rvalid_r;
  assign UPPER_BASE_OUT = upper_base_r;
  assign PRI_BUS_OUT = pri_r;
  assign SEC_BUS_OUT = sec_r;
  assign SUB_BUS_OUT = sub_r;
  assign IO_BOTTOM_OUT = bot_r;
  assign IO_TOP_OUT = top_r;
  assign IO_FWD_OUT = fwd_r;
endmodule : bbiow_regs

// ===== dv/bbiow_monitor.sv
`timescale 1ns/1ps
module bbiow_monitor (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CFG_RD_IN,
  input wire logic PRELOAD_IN,
  input wire logic IO_REQ_IN,
  input wire logic CFG_RVALID_OUT,
  input wire logic IO_FWD_OUT,
  input wire logic [1:0] BAR_TYPE_IN,
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic [31:0] CFG_RDATA_OUT,
  input wire logic [31:0] UPPER_BASE_OUT,
  input wire logic [31:0] IO_TOP_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  ub_hold_a: assert property (BAR_TYPE_IN != 2'h2 && !PRELOAD_IN
    |=> $stable(UPPER_BASE_OUT)) else $error("upper moved");
  rd_ans_a: assert property (CFG_RD_IN |=> CFG_RVALID_OUT) else $error("no rvalid");
  rv_cause_a: assert property (CFG_RVALID_OUT |-> $past(CFG_RD_IN)) else $error("stray rvalid");
  rd_idle_a: assert property (!CFG_RD_IN |=> CFG_RDATA_OUT == 32'h0) else $error("rdata idle");
  io_ind_a: assert property (CFG_RD_IN && CFG_ADDR_IN == 8'h1C
    |=> CFG_RDATA_OUT[11:8] == 4'h1 && CFG_RDATA_OUT[3:0] == 4'h1) else $error("io ind");
  lat_zero_a: assert property (CFG_RD_IN && CFG_ADDR_IN == 8'h18
    |=> CFG_RDATA_OUT[31:24] == 8'h0) else $error("lat byte");
  top_ones_a: assert property ($past(RST_B_IN, 2) && $past(RST_B_IN)
    |-> IO_TOP_OUT[11:0] == 12'hFFF) else $error("top low");
  fwd_idle_a: assert property (!IO_REQ_IN |=> !IO_FWD_OUT) else $error("fwd idle");
endmodule : bbiow_monitor
bind bbiow_regs bbiow_monitor mon (.*);

// ===== dv/bbiow_host.sv
`timescale 1ns/1ps
module bbiow_host (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic [3:0] be_out
);
  initial {wr_out, rd_out, addr_out, wdata_out, be_out} = '0;
  task automatic cfg(
    input logic w,
    input logic [7:0] a,
    input logic [31:0] d,
    input logic [3:0] b
  );
    @(posedge clk_in) #1;
    {wr_out, rd_out, addr_out, wdata_out, be_out} = {w, !w, a, d, b};
    @(posedge clk_in) #1;
    {wr_out, rd_out, addr_out, wdata_out} = {2'h0, ~a, ~d};
  endtask : cfg
endmodule : bbiow_host

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic REF_CLK_IN = '0, RST_B_IN = '0, CFG_WR_IN, CFG_RD_IN, PRELOAD_IN = '0, IO_REQ_IN = '0;
  logic CFG_RVALID_OUT, IO_FWD_OUT;
  logic [1:0] BAR_TYPE_IN = '0;
  logic [3:0] CFG_BE_IN;
  logic [7:0] CFG_ADDR_IN, PRELOAD_ADDR_IN = '0, PRI_BUS_OUT, SEC_BUS_OUT, SUB_BUS_OUT;
  logic [15:0] IO_UPPER_BASE_IN = 16'h1, IO_UPPER_LIMIT_IN = 16'h1;
  logic [31:0] CFG_WDATA_IN, PRELOAD_DATA_IN = '0, IO_ADDR_IN = '0, CFG_RDATA_OUT, UPPER_BASE_OUT;
  logic [31:0] IO_BOTTOM_OUT, IO_TOP_OUT;
  int bad_count = 0, n_tests = 0;
  always #2 REF_CLK_IN = ~REF_CLK_IN;
  bbiow_regs uut (.*);
  bbiow_host host (.clk_in(REF_CLK_IN), .wr_out(CFG_WR_IN), .rd_out(CFG_RD_IN),
    .addr_out(CFG_ADDR_IN), .wdata_out(CFG_WDATA_IN), .be_out(CFG_BE_IN));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.cfg(1'h0, a, 32'h0, 4'h0);
    chk(CFG_RDATA_OUT, e);
    chk(32'(CFG_RVALID_OUT), 32'h1);
  endtask : rd
  task automatic t_regs;
    host.cfg(1'h1, 8'h14, 32'h1234_5678, 4'hF);
    rd(8'h14, 32'h0);
    chk(UPPER_BASE_OUT, 32'h0);
    BAR_TYPE_IN = 2'h2;
    host.cfg(1'h1, 8'h14, 32'h1234_5678, 4'hF);
    rd(8'h14, 32'h1234_5678);
    chk(UPPER_BASE_OUT, 32'h1234_5678);
    BAR_TYPE_IN = 2'h3;
    host.cfg(1'h1, 8'h14, 32'h0, 4'hF);
    rd(8'h14, 32'h1234_5678);
    BAR_TYPE_IN = 2'h2;
    host.cfg(1'h1, 8'h18, 32'hFF03_0201, 4'hF);
    chk({8'h00, SUB_BUS_OUT, SEC_BUS_OUT, PRI_BUS_OUT}, 32'h3_0201);
    rd(8'h18, 32'h3_0201);
    rd(8'h20, 32'h0);
  endtask : t_regs
  task automatic t_io;
    logic [31:0] adr [4] = '{32'h1_9FFF, 32'h1_A000, 32'h1_FFFF, 32'h2_0000};
    host.cfg(1'h1, 8'h1C, 32'hF0A0, 4'h3);
    rd(8'h1C, 32'hF1A1);
    chk(IO_BOTTOM_OUT, 32'h1_A000);
    chk(IO_TOP_OUT, 32'h1_FFFF);
    for (int i = 0; i < 4; i++) begin
      IO_REQ_IN = 1'h1;
      IO_ADDR_IN = adr[i];
      @(posedge REF_CLK_IN) #1;
      chk(32'(IO_FWD_OUT), 32'(adr[i] >= 32'h1_A000 && adr[i] <= 32'h1_FFFF));
    end
    IO_REQ_IN = 1'h0;
    IO_UPPER_BASE_IN = 16'h3;
    IO_UPPER_LIMIT_IN = 16'h4;
    @(posedge REF_CLK_IN) #1;
    chk(IO_BOTTOM_OUT, 32'h3_A000);
    chk(IO_TOP_OUT, 32'h4_FFFF);
  endtask : t_io
  task automatic t_preload;
    fork
      host.cfg(1'h1, 8'h18, 32'h0, 4'hF);
      begin
        @(posedge REF_CLK_IN) #1;
        {PRELOAD_IN, PRELOAD_ADDR_IN, PRELOAD_DATA_IN} = {1'h1, 8'h18, 32'hAA07_0605};
        @(posedge REF_CLK_IN) #1;
        PRELOAD_IN = 1'h0;
      end
    join
    chk({8'h00, SUB_BUS_OUT, SEC_BUS_OUT, PRI_BUS_OUT}, 32'h7_0605);
    rd(8'h18, 32'h7_0605);
  endtask : t_preload
  task automatic t_reset(input logic pulse);
    if (pulse) begin
      @(posedge REF_CLK_IN) #1;
      RST_B_IN = 1'h0;
      repeat (2) @(posedge REF_CLK_IN);
      #1 RST_B_IN = 1'h1;
    end
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h101);
    chk(IO_BOTTOM_OUT, {IO_UPPER_BASE_IN, 16'h0000});
    chk(IO_TOP_OUT, {IO_UPPER_LIMIT_IN, 16'h0FFF});
  endtask : t_reset
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (5) @(posedge REF_CLK_IN);
    #1 RST_B_IN = 1'h1;
    t_reset(1'h0);
    t_regs();
    t_preload();
    t_io();
    t_reset(1'h1);
    conclude();
  end
  initial begin
    #4000 bad_count++;
    conclude();
  end
endmodule : tb_top
